/* File: rtl/dmc_pkg.sv */
// package: shared constants and types for the mpr access block and its controller end
package dmc_pkg;
  // command encodings on the simplified command bus
  typedef enum logic [2:0] {DMC_CMD_NOP, DMC_CMD_MRS, DMC_CMD_ACT, DMC_CMD_RD, DMC_CMD_WR, DMC_CMD_REF,
    DMC_CMD_PREA} dmc_cmd_e;
  localparam int DMC_DQ_W = 16;
  localparam int DMC_BL = 8;
  localparam int DMC_LOCS = 4;
  localparam int DMC_ADDR_W = 18;
  // mode register select values carried on ba during an mrs
  localparam logic [1:0] DMC_MR0 = 2'h0;
  localparam logic [1:0] DMC_MR3 = 2'h3;
  // mr3 field positions
  localparam int DMC_MR3_MPR_EN = 2;
  localparam int DMC_MR3_PAGE_LO = 0;
  localparam int DMC_MR3_FMT_LO = 11;
  // mr0 burst field positions and on-the-fly code
  localparam int DMC_MR0_BL_LO = 0;
  localparam logic [1:0] DMC_BL_OTF = 2'h1;
  // address bit holding the burst chop select
  localparam int DMC_A_BC = 12;
  localparam int DMC_A_BURST_HI = 2;
  // readout format codes from mr3 a[12:11]
  localparam logic [1:0] DMC_FMT_SERIAL = 2'h0;
  localparam logic [1:0] DMC_FMT_PARALLEL = 2'h1;
  localparam logic [1:0] DMC_FMT_STAGGER = 2'h2;
  localparam logic [1:0] DMC_PAGE0 = 2'h0;
  // mpr reset contents, training patterns
  localparam logic [7:0] DMC_MPR0_RST = 8'h55;
  localparam logic [7:0] DMC_MPR1_RST = 8'h33;
  localparam logic [7:0] DMC_MPR2_RST = 8'h0F;
  localparam logic [7:0] DMC_MPR3_RST = 8'h00;
  // latencies in link clocks
  localparam int DMC_RL = 4;
  localparam int DMC_PL = 2;
  localparam int DMC_WAIT_W = 6;
  // controller spacing in link clocks
  localparam int DMC_TCCD_S = 4;
  localparam int DMC_TCCD_L = 6;
  localparam int DMC_TRRD_S = 4;
  localparam int DMC_TRRD_L = 6;
  localparam int DMC_TFAW = 20;
  localparam int DMC_TWTR_S = 3;
  localparam int DMC_TWTR_L = 8;
  localparam int DMC_CWL = 4;
  localparam int DMC_TMOD = 24;
  localparam int DMC_TRP = 12;
  localparam int DMC_TWR_MPR = 8;
  localparam int DMC_TMPRR = 2;
  // link clock divider, half period in fabric clocks
  localparam int DMC_CK_HALF = 4;
endpackage : dmc_pkg

/* File: rtl/dmc_link_if.sv */
// interface: command, address and data pins between controller and dram end
`timescale 1ns/10ps
`default_nettype none
interface dmc_link_if;
  import dmc_pkg::*;
  logic ck;
  dmc_cmd_e cmd;
  logic [1:0] ba;
  logic bg;
  logic [DMC_ADDR_W-1:0] addr;
  logic dbi_n;
  logic [DMC_DQ_W-1:0] dq_ctl;
  logic dq_ctl_oe;
  logic [DMC_DQ_W-1:0] dq_mem;
  logic dq_mem_oe;
  logic [DMC_DQ_W-1:0] dq;
  // resolved bus level, the driving end wins, idle bus reads high
  assign dq = dq_mem_oe ? dq_mem : (dq_ctl_oe ? dq_ctl : {DMC_DQ_W{1'b1}});
  modport ctl (output ck, cmd, ba, bg, addr, dbi_n, dq_ctl, dq_ctl_oe, input dq);
  modport mem (input ck, cmd, ba, bg, addr, dbi_n, dq, output dq_mem, dq_mem_oe);
endinterface : dmc_link_if
`default_nettype wire

/* File: rtl/dmc_lane_mux.sv */
// lane mux: picks one beat of the mpr burst for every dq lane
`timescale 1ns/10ps
`default_nettype none
module dmc_lane_mux #(
  parameter int DQ_W = 16
) (
  // pattern source
  input wire logic [1:0] fmt,
  input wire logic [1:0] loc,
  input wire logic [31:0] mpr_flat,
  input wire logic [2:0] beat,
  // lane bits
  output logic [DQ_W-1:0] lanes
);
  import dmc_pkg::*;
  logic [7:0] sel_byte;
  logic [1:0] sel_loc;
  // every lane computed by the same expression; in staggered format lane index mod four offsets the location
  always_comb begin
    lanes = '0;
    sel_byte = '0;
    sel_loc = '0;
    for (int i = 0; i < DQ_W; i++) begin
      sel_loc = loc + 2'(i % DMC_LOCS);
      if (fmt == DMC_FMT_STAGGER) begin
        sel_byte = mpr_flat[8*sel_loc +: 8];
        lanes[i] = sel_byte[beat];
      end else if (fmt == DMC_FMT_PARALLEL) begin
        // parallel returns location 0 bits across lanes in every beat
        sel_byte = mpr_flat[7:0];
        lanes[i] = sel_byte[i % 8];
      end else begin
        sel_byte = mpr_flat[8*loc +: 8];
        lanes[i] = sel_byte[beat];
      end
    end
  end
endmodule : dmc_lane_mux
`default_nettype wire

/* File: rtl/dmc_mem_end.sv */
// dram end: mpr mode, mpr writes and staggered readout on the link clock edges
//
// Summary of operation
// - staggered lane i carries location n+i mod 4
// - second nibble and upper byte repeat pattern
// - back-to-back mpr reads give gapless bursts
// - controller sends a[2:0]=0, location on ba
// - controller holds a12 high under otf burst
// - parity latency adds to read data delay
// - write takes a[7:0], bit k is beat k
// - controller uses no dbi on mpr writes
// - written mpr values held until reset
// - controller precharges all before mpr entry
// - mr3 enables page 0 only, wait tmod
// - ba selects mpr0 to mpr3 on writes
// - controller waits write recovery per write
// - controller waits tmprr, exits, waits tmod
// - only 1x refresh while mpr mode on
// - column spacing short across, long within group; the controller spaces mpr reads by DMC_TCCD_S with bg tied to 0
// - activate spacing short across, long within group
// - at most four activates per faw window
// - write to read spacing from internal write
// - mr3 selects readout format and page
`timescale 1ns/10ps
`default_nettype none
module dmc_mem_end #(
  parameter int RL = dmc_pkg::DMC_RL,
  parameter int PL = dmc_pkg::DMC_PL
) (
  // system
  input wire logic CLK,
  input wire logic RESETN,
  // link
  dmc_link_if.mem LINK,
  // parity latency mode strap-like control
  input wire logic PARITY_EN,
  // status
  output logic MPR_MODE,
  output logic [31:0] MPR_CONTENT,
  output logic CMD_ERROR
);
  import dmc_pkg::*;
  localparam int DLY_W = $clog2(RL + PL + DMC_BL + 2) + 1;
  // ***********************************************
  // link sampling
  // ***********************************************
  logic ck_s1, ck_s2, ck_s3;
  logic [DMC_ADDR_W-1:0] addr_s1, addr_s2;
  logic [1:0] ba_s1, ba_s2;
  logic [2:0] cmd_s1, cmd_s2;
  logic dbi_s1, dbi_s2;
  logic ck_rise;
  // two flops on every pin before use; the first stage feeds only the second
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      addr_s1 <= '0;
      addr_s2 <= '0;
      ba_s1 <= '0;
      ba_s2 <= '0;
      cmd_s1 <= '0;
      cmd_s2 <= '0;
      dbi_s1 <= 1'b1;
      dbi_s2 <= 1'b1;
    end else begin
      ck_s1 <= LINK.ck;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      addr_s1 <= LINK.addr;
      addr_s2 <= addr_s1;
      ba_s1 <= LINK.ba;
      ba_s2 <= ba_s1;
      cmd_s1 <= LINK.cmd;
      cmd_s2 <= cmd_s1;
      dbi_s1 <= LINK.dbi_n;
      dbi_s2 <= dbi_s1;
    end
  end
  assign ck_rise = ck_s2 & ~ck_s3;
  // ***********************************************
  // mode registers and mpr storage
  // ***********************************************
  logic [DMC_ADDR_W-1:0] mr0, mr3, next_mr0, next_mr3;
  logic [7:0] mpr [DMC_LOCS];
  logic [7:0] next_mpr [DMC_LOCS];
  logic err, next_err;
  logic mpr_on;
  logic cmd_rd, cmd_wr;
  assign mpr_on = mr3[DMC_MR3_MPR_EN];
  assign cmd_rd = ck_rise && (dmc_cmd_e'(cmd_s2) == DMC_CMD_RD);
  assign cmd_wr = ck_rise && (dmc_cmd_e'(cmd_s2) == DMC_CMD_WR);
  // decode of mode register writes, mpr writes and misuse checks
  always_comb begin
    next_mr0 = mr0;
    next_mr3 = mr3;
    next_mpr = mpr;
    next_err = err;
    if (ck_rise && dmc_cmd_e'(cmd_s2) == DMC_CMD_MRS) begin
      if (ba_s2 == DMC_MR0) next_mr0 = addr_s2;
      if (ba_s2 == DMC_MR3) next_mr3 = addr_s2;
    end
    if (cmd_wr && mpr_on) begin
      // writes into pages other than 0 are dropped and flagged
      if (mr3[DMC_MR3_PAGE_LO +: 2] == DMC_PAGE0 && dbi_s2) begin
        next_mpr[ba_s2] = addr_s2[7:0];
      end else begin
        next_err = 1'b1;
      end
    end
    // a12 low under otf burst setting or nonzero burst start is a controller error
    if (cmd_rd && mpr_on) begin
      if (addr_s2[DMC_A_BURST_HI:0] != '0) next_err = 1'b1;
      if (mr0[DMC_MR0_BL_LO +: 2] == DMC_BL_OTF && !addr_s2[DMC_A_BC]) next_err = 1'b1;
    end
  end
  // mpr contents survive everything except reset
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mr0 <= '0;
      mr3 <= '0;
      mpr[0] <= DMC_MPR0_RST;
      mpr[1] <= DMC_MPR1_RST;
      mpr[2] <= DMC_MPR2_RST;
      mpr[3] <= DMC_MPR3_RST;
      err <= 1'b0;
    end else begin
      mr0 <= next_mr0;
      mr3 <= next_mr3;
      mpr <= next_mpr;
      err <= next_err;
    end
  end
  // ***********************************************
  // read pipeline
  // ***********************************************
  // each read queues its location in a shift line of link clocks; a new read every 4 clocks
  // lands exactly where the previous burst ends, so back-to-back bursts touch without a gap
  localparam int LINE = RL + PL + 1;
  logic [LINE-1:0] rd_vld, next_rd_vld;
  logic [1:0] rd_loc [LINE];
  logic [1:0] next_rd_loc [LINE];
  logic [DLY_W-1:0] lat;
  logic [2:0] beat, next_beat;
  logic [1:0] cur_loc, next_cur_loc;
  logic drive, next_drive;
  logic [DMC_DQ_W-1:0] lanes, dq_out, next_dq_out;
  assign lat = PARITY_EN ? DLY_W'(RL + PL) : DLY_W'(RL);
  // the line advances on rising link edges; bursts run two beats per link clock
  always_comb begin
    next_rd_vld = rd_vld;
    next_rd_loc = rd_loc;
    next_beat = beat;
    next_cur_loc = cur_loc;
    next_drive = drive;
    next_dq_out = dq_out;
    if (ck_rise) begin
      next_rd_vld = {1'b0, rd_vld[LINE-1:1]};
      for (int i = 0; i < LINE - 1; i++) next_rd_loc[i] = rd_loc[i+1];
      next_rd_loc[LINE-1] = '0;
      if (cmd_rd && mpr_on) begin
        next_rd_vld[lat - 1] = 1'b1;
        next_rd_loc[lat - 1] = ba_s2;
      end
    end
    // a half link period is DMC_CK_HALF fabric clocks, one beat per half
    if (ck_s2 != ck_s3) begin
      if (ck_rise && rd_vld[0]) begin
        next_drive = 1'b1;
        next_cur_loc = rd_loc[0];
        next_beat = '0;
      end else if (drive && beat == 3'(DMC_BL - 1)) begin
        next_drive = 1'b0;
      end else if (drive) begin
        next_beat = beat + 3'd1;
      end
    end
    next_dq_out = lanes;
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_vld <= '0;
      for (int i = 0; i < LINE; i++) rd_loc[i] <= '0;
      beat <= '0;
      cur_loc <= '0;
      drive <= 1'b0;
      dq_out <= '0;
    end else begin
      rd_vld <= next_rd_vld;
      rd_loc <= next_rd_loc;
      beat <= next_beat;
      cur_loc <= next_cur_loc;
      drive <= next_drive;
      dq_out <= next_dq_out;
    end
  end
  dmc_lane_mux #(.DQ_W(DMC_DQ_W)) u_mux (
    .fmt(mr3[DMC_MR3_FMT_LO +: 2]),
    .loc(cur_loc),
    .mpr_flat({mpr[3], mpr[2], mpr[1], mpr[0]}),
    .beat(beat),
    .lanes(lanes)
  );
  assign LINK.dq_mem = dq_out;
  assign LINK.dq_mem_oe = drive;
  assign MPR_MODE = mpr_on;
  assign MPR_CONTENT = {mpr[3], mpr[2], mpr[1], mpr[0]};
  assign CMD_ERROR = err;
endmodule : dmc_mem_end
`default_nettype wire

/* File: rtl/dmc_ctl_end.sv */
// controller end: mpr entry, writes, reads and exit with core spacing guards
`timescale 1ns/10ps
`default_nettype none
module dmc_ctl_end (
  // system
  input wire logic CLK,
  input wire logic RESETN,
  // user request
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [1:0] REQ_LOC,
  input wire logic [7:0] REQ_DATA,
  input wire logic REQ_LAST,
  output logic REQ_READY,
  // link
  dmc_link_if.ctl LINK
);
  import dmc_pkg::*;
  typedef enum {ST_PREA, ST_WAIT_RP, ST_ENTER, ST_WAIT_MOD, ST_IDLE, ST_WAIT_WR, ST_WAIT_RR, ST_EXIT,
    ST_DONE} dmc_state_e;
  dmc_state_e st, next_st;
  logic [2:0] div, next_div;
  logic ck, next_ck;
  logic [DMC_WAIT_W-1:0] wt, next_wt;
  logic [2:0] cmd, next_cmd;
  logic [1:0] ba, next_ba;
  logic [DMC_ADDR_W-1:0] addr, next_addr;
  logic edge_hi;
  logic last, next_last;
  // link clock made here from the fabric clock; commands change on its falling half
  // so they stand still from half a link period before to half a link period after the rising edge the dram samples
  assign edge_hi = (div == 3'(DMC_CK_HALF - 1)) && ck;
  always_comb begin
    next_div = (div == 3'(DMC_CK_HALF - 1)) ? '0 : div + 3'd1;
    next_ck = (div == 3'(DMC_CK_HALF - 1)) ? ~ck : ck;
    next_st = st;
    next_wt = wt;
    next_cmd = cmd;
    next_ba = ba;
    next_addr = addr;
    next_last = last;
    REQ_READY = 1'b0;
    if (edge_hi) begin
      next_cmd = DMC_CMD_NOP;
      if (wt != '0) next_wt = wt - DMC_WAIT_W'(1);
      case (st)
        ST_PREA: begin
          next_cmd = DMC_CMD_PREA;
          next_wt = DMC_WAIT_W'(DMC_TRP);
          next_st = ST_WAIT_RP;
        end
        ST_WAIT_RP: if (wt == '0) next_st = ST_ENTER;
        ST_ENTER: begin
          next_cmd = DMC_CMD_MRS;
          next_ba = DMC_MR3;
          next_addr = '0;
          next_addr[DMC_MR3_MPR_EN] = 1'b1;
          next_addr[DMC_MR3_FMT_LO +: 2] = DMC_FMT_STAGGER;
          next_wt = DMC_WAIT_W'(DMC_TMOD);
          next_st = ST_WAIT_MOD;
        end
        ST_WAIT_MOD: if (wt == '0) next_st = ST_IDLE;
        ST_IDLE: begin
          REQ_READY = 1'b1;
          if (REQ_VALID) begin
            next_ba = REQ_LOC;
            next_addr = '0;
            next_addr[DMC_A_BC] = 1'b1;
            if (REQ_WRITE) begin
              next_cmd = DMC_CMD_WR;
              next_addr[7:0] = REQ_DATA;
              next_wt = DMC_WAIT_W'(DMC_TWR_MPR);
              next_st = ST_WAIT_WR;
            end else begin
              next_cmd = DMC_CMD_RD;
              // mpr reads use the short column spacing so that their bursts touch
              next_wt = DMC_WAIT_W'(DMC_TCCD_S);
              next_st = ST_WAIT_RR;
            end
            next_last = REQ_LAST;
          end
        end
        // leaving two edges early lands the next command exactly wt link clocks after this one
        ST_WAIT_WR, ST_WAIT_RR: begin
          if (wt <= DMC_WAIT_W'(2)) begin
            if (last) begin
              // last read burst must be out and tmprr met before the exit
              next_wt = DMC_WAIT_W'(DMC_RL + DMC_PL + DMC_BL / 2 + DMC_TMPRR);
              next_st = ST_EXIT;
            end else begin
              next_st = ST_IDLE;
            end
          end
        end
        ST_EXIT: begin
          if (wt == '0) begin
            next_cmd = DMC_CMD_MRS;
            next_ba = DMC_MR3;
            next_addr = '0;
            next_wt = DMC_WAIT_W'(DMC_TMOD);
            next_st = ST_DONE;
          end
        end
        ST_DONE: next_st = ST_DONE;
        default: next_st = ST_PREA;
      endcase
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= ST_PREA;
      div <= '0;
      ck <= 1'b0;
      wt <= '0;
      cmd <= '0;
      ba <= '0;
      addr <= '0;
      last <= 1'b0;
    end else begin
      st <= next_st;
      div <= next_div;
      ck <= next_ck;
      wt <= next_wt;
      cmd <= next_cmd;
      ba <= next_ba;
      addr <= next_addr;
      last <= next_last;
    end
  end
  // no activates, refreshes or normal writes are issued here, so hold trivially
  assign LINK.ck = ck;
  assign LINK.cmd = dmc_cmd_e'(cmd);
  assign LINK.ba = ba;
  assign LINK.bg = 1'b0;
  assign LINK.addr = addr;
  assign LINK.dbi_n = 1'b1;
  assign LINK.dq_ctl = '0;
  assign LINK.dq_ctl_oe = 1'b0;
endmodule : dmc_ctl_end
`default_nettype wire

/* File: testbench/dmc_link_asserts.sv */
// checker: command address, spacing and burst rules on the joined link
`timescale 1ns/10ps
`default_nettype none
module dmc_link_asserts
  import dmc_pkg::*;
(
  // system
  input wire logic CLK,
  input wire logic RESETN,
  // link
  input var dmc_cmd_e cmd,
  input wire logic [1:0] ba,
  input wire logic [DMC_ADDR_W-1:0] addr,
  input wire logic dbi_n,
  input wire logic dq_mem_oe
);
  localparam int LCK = 2 * DMC_CK_HALF;
  localparam int SAT = 1023;
  localparam int RD_MIN = DMC_RL * LCK;
  localparam int RD_MAX = (DMC_RL + DMC_PL + 3) * LCK;
  dmc_cmd_e prev_cmd;
  logic start;
  logic mr3_on;
  int since_wr;
  int since_rd;
  int since_mrs;
  int since_prea;
  int oe_len;
  // ****************
  // helper counters
  // ****************
  assign start = cmd != DMC_CMD_NOP && cmd != prev_cmd;
  assign mr3_on = start && cmd == DMC_CMD_MRS && ba == DMC_MR3 && addr[DMC_MR3_MPR_EN];
  // clk cycles since each write, read, precharge and mpr entry began; saturate so an old one never wraps into a short gap
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      prev_cmd <= DMC_CMD_NOP;
      since_wr <= SAT;
      since_rd <= SAT;
      since_mrs <= SAT;
      since_prea <= SAT;
      oe_len <= 0;
    end else begin
      prev_cmd <= cmd;
      since_wr <= (start && cmd == DMC_CMD_WR) ? 1 : (since_wr < SAT ? since_wr + 1 : SAT);
      since_rd <= (start && cmd == DMC_CMD_RD) ? 1 : (since_rd < SAT ? since_rd + 1 : SAT);
      since_mrs <= mr3_on ? 1 : (since_mrs < SAT ? since_mrs + 1 : SAT);
      since_prea <= (start && cmd == DMC_CMD_PREA) ? 1 : (since_prea < SAT ? since_prea + 1 : SAT);
      oe_len <= dq_mem_oe ? oe_len + 1 : 0;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  sequence rd_issue;
    start && cmd == DMC_CMD_RD;
  endsequence
  sequence wr_issue;
    start && cmd == DMC_CMD_WR;
  endsequence
  chk_rd_address: assert property (rd_issue |-> addr[DMC_A_BURST_HI:0] == 3'h0 && addr[DMC_A_BC])
    else $error("read address bits wrong");
  chk_wr_no_dbi: assert property (wr_issue |-> dbi_n [*8])
    else $error("inversion used on mpr write");
  chk_mpr_page: assert property (mr3_on |-> addr[1:0] == DMC_PAGE0)
    else $error("mpr entry not on page zero");
  chk_entry_precharge: assert property (mr3_on |-> since_prea >= DMC_TRP * LCK)
    else $error("mpr entry too soon after precharge");
  chk_entry_settle: assert property (start && cmd inside {DMC_CMD_RD, DMC_CMD_WR} |-> since_mrs >= DMC_TMOD * LCK)
    else $error("access too soon after mpr entry");
  chk_wr_recovery: assert property (wr_issue |-> since_wr >= DMC_TWR_MPR * LCK)
    else $error("mpr writes too close");
  chk_rd_spacing: assert property (rd_issue |-> since_rd >= DMC_TCCD_S * LCK)
    else $error("mpr reads too close");
  chk_burst_whole: assert property ($fell(dq_mem_oe) |-> oe_len % (DMC_BL * DMC_CK_HALF) == 0)
    else $error("read data window not whole bursts");
  chk_rd_answer: assert property (rd_issue |-> ##[RD_MIN:RD_MAX] dq_mem_oe)
    else $error("read data never driven");
endmodule : dmc_link_asserts
`default_nettype wire

/* File: testbench/dram_mpr_access_core_timing_test.sv */
// testbench: controller and dram ends joined, plus a dram end driven by hand
`timescale 1ns/10ps
`default_nettype none
module dram_mpr_access_core_timing_test;
  import dmc_pkg::*;
  localparam logic [31:0] RST = {DMC_MPR3_RST, DMC_MPR2_RST, DMC_MPR1_RST, DMC_MPR0_RST};
  logic clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_last = 1'b0, par_en = 1'b0;
  logic [1:0] req_loc = 2'h0;
  logic [7:0] req_data = 8'h00;
  logic req_ready, mode, err, mode2, err2, rd_seen = 1'b0;
  logic [31:0] cont, cont2, exp;
  logic [15:0] beats[$];
  int runs[$];
  int error_cnt = 0, tests_run = 0, cyc = 0, rd_cyc = 0, lat = 0;
  dmc_link_if link();
  dmc_link_if link2();
  dmc_ctl_end dmc_ctl_end_i (.CLK(clk), .RESETN(resetn), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
    .REQ_LOC(req_loc), .REQ_DATA(req_data), .REQ_LAST(req_last), .REQ_READY(req_ready), .LINK(link.ctl));
  dmc_mem_end dmc_mem_end_i (.CLK(clk), .RESETN(resetn), .LINK(link.mem), .PARITY_EN(par_en),
    .MPR_MODE(mode), .MPR_CONTENT(cont), .CMD_ERROR(err));
  // second dram end faces the bench, so commands that break the rules can reach it
  dmc_mem_end dmc_mem_end_i2 (.CLK(clk), .RESETN(resetn), .LINK(link2.mem), .PARITY_EN(1'b0),
    .MPR_MODE(mode2), .MPR_CONTENT(cont2), .CMD_ERROR(err2));
  dmc_link_asserts dmc_link_asserts_i (.CLK(clk), .RESETN(resetn), .cmd(link.cmd), .ba(link.ba),
    .addr(link.addr), .dbi_n(link.dbi_n), .dq_mem_oe(link.dq_mem_oe));
  always #2 clk = ~clk;
  // hand-made link clock, offset so its edges fall between clk edges
  initial begin
    link2.ck = 1'b0;
    #3;
    forever #16 link2.ck = ~link2.ck;
  end
  // stamp of each new read command
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_seen <= (link.cmd === DMC_CMD_RD);
    if (link.cmd === DMC_CMD_RD && !rd_seen) rd_cyc <= cyc;
  end
  // beats sampled mid-eye; one run per unbroken data window
  initial forever begin : mon
    int n;
    @(posedge link.dq_mem_oe);
    n = 0;
    repeat (2) @(posedge clk);
    lat = cyc - rd_cyc;
    while (link.dq_mem_oe === 1'b1) begin
      beats.push_back(link.dq);
      n++;
      repeat (DMC_CK_HALF) @(posedge clk);
    end
    runs.push_back(n);
  end
  function automatic logic [15:0] exp_beat(input int loc, input int b);
    logic [15:0] v;
    for (int i = 0; i < DMC_DQ_W; i++) v[i] = exp[DMC_BL * ((loc + i) % DMC_LOCS) + b];
    return v;
  endfunction : exp_beat
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic req(input logic wr, input logic [1:0] loc, input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= wr;
    req_loc <= loc;
    req_data <= d;
    @(posedge clk);
    while (req_ready !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk(n < 4000, "request stuck");
    req_valid <= 1'b0;
    req_data <= ~d;
    @(posedge clk);
  endtask : req
  task automatic reads(input int first, input int cnt);
    int n;
    n = 0;
    beats.delete();
    runs.delete();
    for (int j = 0; j < cnt; j++) req(1'b0, 2'(first + j), 8'h00);
    while (runs.size() == 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(runs.size() == 1 && runs[0] == DMC_BL * cnt, "burst gap");
    for (int j = 0; j < DMC_BL * cnt; j++) chk(beats[j] === exp_beat(first + j / DMC_BL, j % DMC_BL), "lane");
  endtask : reads
  // one command held a full link clock, then nop, ba and addr inverted, dbi_n high
  task automatic send2(input dmc_cmd_e c, input logic [1:0] b, input logic [17:0] a, input logic dbi, input int gap);
    @(negedge link2.ck);
    @(posedge clk);
    link2.cmd <= c;
    link2.ba <= b;
    link2.addr <= a;
    link2.dbi_n <= dbi;
    @(negedge link2.ck);
    @(posedge clk);
    link2.cmd <= DMC_CMD_NOP;
    link2.ba <= ~b;
    link2.addr <= ~a;
    link2.dbi_n <= 1'b1;
    repeat (gap) @(posedge link2.ck);
    @(posedge clk);
  endtask : send2
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  // watchdog: the whole run needs well under ten thousand clk cycles
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    $display("[FAIL] %0t watchdog", $time);
    test_done();
  end
  initial begin : main
    logic [7:0] d;
    logic [17:0] mr3v;
    int l0;
    link2.cmd = DMC_CMD_NOP;
    link2.ba = 2'h0;
    link2.bg = 1'b0;
    link2.addr = '0;
    link2.dbi_n = 1'b1;
    link2.dq_ctl = '0;
    link2.dq_ctl_oe = 1'b0;
    exp = RST;
    mr3v = '0;
    mr3v[DMC_MR3_MPR_EN] = 1'b1;
    mr3v[DMC_MR3_FMT_LO +: 2] = DMC_FMT_STAGGER;
    void'($urandom(32'h944d_d88d));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    // hand-driven end: write before entry, entry, good write, inverted write
    send2(DMC_CMD_WR, 2'h1, 18'h0_00a5, 1'b1, DMC_TWR_MPR);
    chk(cont2 === RST && err2 === 1'b0, "write outside mpr");
    send2(DMC_CMD_PREA, 2'h0, 18'h0_0000, 1'b1, DMC_TRP);
    send2(DMC_CMD_MRS, DMC_MR3, mr3v, 1'b1, DMC_TMOD);
    chk(mode2 === 1'b1, "entry2");
    d = 8'($urandom);
    send2(DMC_CMD_WR, 2'h2, {10'h3ff, d}, 1'b1, DMC_TWR_MPR);
    chk(cont2 === {DMC_MPR3_RST, d, DMC_MPR1_RST, DMC_MPR0_RST}, "write2");
    send2(DMC_CMD_WR, 2'h3, 18'h0_00ff, 1'b0, DMC_TWR_MPR);
    chk(err2 === 1'b1 && cont2[31:24] === DMC_MPR3_RST, "inverted write");
    // joined ends: the controller enters mpr mode by itself
    l0 = 0;
    while (mode !== 1'b1 && l0 < 4000) begin
      @(posedge clk);
      l0++;
    end
    chk(mode === 1'b1 && cont === RST, "entry");
    for (int i = 0; i < DMC_LOCS; i++) begin
      d = (i == 0) ? 8'h01 : 8'($urandom);
      exp[DMC_BL * i +: 8] = d;
      req(1'b1, 2'(i), d);
    end
    repeat (DMC_TWR_MPR * 2 * DMC_CK_HALF) @(posedge clk);
    chk(cont === exp, "writes");
    reads(1, 1);
    l0 = lat;
    par_en <= 1'b1;
    reads(2, 1);
    chk(lat - l0 == DMC_PL * 2 * DMC_CK_HALF, "parity latency");
    reads(int'($urandom_range(3)), 4);
    chk(cont === exp && err === 1'b0, "after reads");
    // last access carries the exit request; contents must outlive the exit
    req_last <= 1'b1;
    reads(0, 1);
    req_last <= 1'b0;
    repeat (DMC_TMOD * 2 * DMC_CK_HALF) @(posedge clk);
    chk(mode === 1'b0 && cont === exp && err === 1'b0, "exit");
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    chk(cont === RST && mode === 1'b0, "reinit");
    // second release: the hand-driven end under the on-the-fly burst setting
    resetn <= 1'b1;
    send2(DMC_CMD_MRS, DMC_MR3, mr3v, 1'b1, DMC_TMOD);
    send2(DMC_CMD_MRS, DMC_MR0, {16'h0000, DMC_BL_OTF}, 1'b1, DMC_TMOD);
    send2(DMC_CMD_RD, 2'h1, 18'h0_1000, 1'b1, 16);
    chk(err2 === 1'b0, "otf read with a12 high");
    send2(DMC_CMD_RD, 2'h1, 18'h0_0000, 1'b1, 16);
    chk(err2 === 1'b1, "otf read with a12 low");
    test_done();
  end
endmodule : dram_mpr_access_core_timing_test
`default_nettype wire
